// *** common/cgr_pkg.sv ***
// Register map, field layout and carrier types for the clock gating and soft reset block
package cgr_pkg;
  localparam logic [11:0] CGR_OFF_SRC_A     = 12'h040;
  localparam logic [11:0] CGR_OFF_SRC_B     = 12'h044;
  localparam logic [11:0] CGR_OFF_RUN_GATE  = 12'h108;
  localparam logic [11:0] CGR_OFF_SLP_GATE  = 12'h118;
  localparam logic [11:0] CGR_OFF_DSL_GATE  = 12'h128;
  localparam logic [11:0] CGR_OFF_RUN_CFG   = 12'h060;
  localparam logic [11:0] CGR_OFF_CAP_ONE   = 12'h010;
  localparam logic [11:0] CGR_OFF_CAP_TWO   = 12'h014;
  localparam logic [11:0] CGR_OFF_IRQ_STAT  = 12'h200;
  localparam logic [11:0] CGR_OFF_IRQ_MASK  = 12'h204;
  localparam logic [11:0] CGR_OFF_STATUS    = 12'h208;

  localparam int          CGR_PORTS         = 8;
  localparam logic [31:0] CGR_PORT_MASK     = 32'h0000_00FF;
  localparam logic [31:0] CGR_SRC_A_MASK    = 32'h0000_0048;
  localparam logic [31:0] CGR_SRC_B_MASK    = 32'h030F_5037;
  localparam int          CGR_HIB_BIT       = 6;
  localparam int          CGR_WDT_BIT       = 3;
  localparam int          CGR_CMP0_BIT      = 24;
  localparam int          CGR_CMP1_BIT      = 25;
  localparam int          CGR_ACG_BIT       = 27;
  localparam logic [31:0] CGR_RUN_CFG_MASK  = 32'h0800_0000;
  localparam logic [31:0] CGR_ZERO          = 32'h0000_0000;

  localparam int          CGR_IRQ_BITS      = 2;
  localparam int          CGR_EV_FAULT      = 0;
  localparam int          CGR_EV_MODE       = 1;

  localparam logic [1:0]  CGR_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  CGR_RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    CGR_MODE_RUN   = 3'h1,
    CGR_MODE_SLEEP = 3'h2,
    CGR_MODE_DEEP  = 3'h4
  } cgr_mode_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        valid;
  } cgr_req_t;

  typedef struct packed {
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [31:0] run_gate;
    logic [31:0] slp_gate;
    logic [31:0] dsl_gate;
    logic [31:0] run_cfg;
    logic [CGR_IRQ_BITS-1:0] irq_stat;
    logic [CGR_IRQ_BITS-1:0] irq_mask;
  } cgr_regs_t;
endpackage

// *** src/cgr_gate_sel.sv ***
`timescale 1ns/1ps
// Selects the active port clock enables from the power mode
module cgr_gate_sel
  import cgr_pkg::*;
(
  input  wire logic [31:0]          run_gate,
  input  wire logic [31:0]          slp_gate,
  input  wire logic [31:0]          dsl_gate,
  input  wire logic                 auto_gate,
  input  wire cgr_mode_t            mode,
  output logic [CGR_PORTS-1:0]      port_en
);
  logic [31:0] pick;
  always_comb begin
    pick = run_gate;
    if (auto_gate) begin
      case (mode)
        CGR_MODE_SLEEP: pick = slp_gate;
        CGR_MODE_DEEP:  pick = dsl_gate;
        default:        pick = run_gate;
      endcase
    end
    port_en = pick[CGR_PORTS-1:0];
  end
endmodule

// *** src/cgr_top.sv ***
`timescale 1ns/1ps
// Clock gating and software reset register block with AXI4-Lite slave

// How it works
// - Gate bit one clocks port, zero stops it
// - Access to gated port answers bus fault
// - All gating bits clear after reset
// - Run, sleep, deep registers select enables
// - Sleep registers apply only with auto gating
// - Ports A-H on bits 7:0, rest zero
// - Reset writes masked by capability registers
// - Reset B: comparators one, zero at 25,24
// - Sleep port gate register at 0x118
module cgr_top
  import cgr_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [31:0]          capabilities_one,
  input  wire logic [31:0]          capabilities_two,
  input  wire cgr_mode_t            power_mode,
  input  wire logic                 port_access,
  input  wire logic [2:0]           port_access_sel,
  output logic [CGR_PORTS-1:0]      port_clk_en,
  output logic                      port_access_fault,
  output logic                      hibernation_unit_reset,
  output logic                      watchdog_unit_reset,
  output logic                      comparator_zero_reset,
  output logic                      comparator_one_reset,
  output logic [31:0]               other_unit_reset,
  output logic                      irq
);

  typedef struct packed {
    cgr_regs_t   r;
    logic [11:0] aw_addr;
    logic        aw_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_have;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
    logic        awready;
    logic        wready;
    logic        arready;
    logic [CGR_PORTS-1:0] clk_en;
    logic        fault;
    logic        irq;
    cgr_mode_t   last_mode;
  } cgr_state_t;

  cgr_state_t  q;
  cgr_state_t  next_q;
  logic [CGR_PORTS-1:0] sel_en;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~m) | (wd & m);
  endfunction

  function automatic logic known(input logic [11:0] a);
    known = (a == CGR_OFF_SRC_A) || (a == CGR_OFF_SRC_B) || (a == CGR_OFF_RUN_GATE) ||
            (a == CGR_OFF_SLP_GATE) || (a == CGR_OFF_DSL_GATE) || (a == CGR_OFF_RUN_CFG) ||
            (a == CGR_OFF_CAP_ONE) || (a == CGR_OFF_CAP_TWO) || (a == CGR_OFF_IRQ_STAT) ||
            (a == CGR_OFF_IRQ_MASK) || (a == CGR_OFF_STATUS);
  endfunction

  cgr_gate_sel u_sel (
    .run_gate  (q.r.run_gate),
    .slp_gate  (q.r.slp_gate),
    .dsl_gate  (q.r.dsl_gate),
    .auto_gate (q.r.run_cfg[CGR_ACG_BIT]),
    .mode      (power_mode),
    .port_en   (sel_en)
  );

  always_comb begin
    logic        do_write;
    logic        do_read;
    logic        fault_now;
    logic [11:0] wa;
    logic [11:0] ra;
    do_write  = 1'b0;
    do_read   = 1'b0;
    fault_now = 1'b0;
    next_q    = q;
    wa        = q.aw_have ? q.aw_addr : s_axi_awaddr;
    ra        = s_axi_araddr;
    if (s_axi_awvalid && q.awready) begin
      next_q.aw_have = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.w_have = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end
    do_write  = next_q.aw_have && next_q.w_have && !q.bvalid;
    wa        = next_q.aw_addr;
    do_read   = s_axi_arvalid && q.arready;
    // Gated port access is reported as a fault on the peripheral side
    fault_now = port_access && !q.clk_en[port_access_sel];
    next_q.fault  = fault_now;
    next_q.clk_en = sel_en;
    if (fault_now) begin
      next_q.r.irq_stat[CGR_EV_FAULT] = 1'b1;
    end
    next_q.last_mode = power_mode;
    if (power_mode != q.last_mode) begin
      next_q.r.irq_stat[CGR_EV_MODE] = 1'b1;
    end
    if (do_write) begin
      next_q.aw_have = 1'b0;
      next_q.w_have  = 1'b0;
      next_q.bvalid  = 1'b1;
      // Response code frozen with bvalid, so it cannot move while stalled
      next_q.bresp   = known(wa) ? CGR_RESP_OKAY : CGR_RESP_SLVERR;
      if (wa == CGR_OFF_SRC_A) begin
        next_q.r.src_a = merge(q.r.src_a, next_q.w_data, next_q.w_strb,
                               CGR_SRC_A_MASK & capabilities_one);
      end else if (wa == CGR_OFF_SRC_B) begin
        next_q.r.src_b = merge(q.r.src_b, next_q.w_data, next_q.w_strb,
                               CGR_SRC_B_MASK & capabilities_two);
      end else if (wa == CGR_OFF_RUN_GATE) begin
        next_q.r.run_gate = merge(q.r.run_gate, next_q.w_data, next_q.w_strb, CGR_PORT_MASK);
      end else if (wa == CGR_OFF_SLP_GATE) begin
        next_q.r.slp_gate = merge(q.r.slp_gate, next_q.w_data, next_q.w_strb,
                                  CGR_PORT_MASK);
      end else if (wa == CGR_OFF_DSL_GATE) begin
        next_q.r.dsl_gate = merge(q.r.dsl_gate, next_q.w_data, next_q.w_strb,
                                  CGR_PORT_MASK);
      end else if (wa == CGR_OFF_RUN_CFG) begin
        next_q.r.run_cfg = merge(q.r.run_cfg, next_q.w_data, next_q.w_strb, CGR_RUN_CFG_MASK);
      end else if (wa == CGR_OFF_IRQ_MASK) begin
        next_q.r.irq_mask = next_q.w_data[CGR_IRQ_BITS-1:0];
      end
      next_q.rresp = q.rresp;
    end
    if (do_write) begin
      next_q.bvalid = 1'b1;
    end else if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (do_read) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = known(ra) ? CGR_RESP_OKAY : CGR_RESP_SLVERR;
      next_q.rdata  = CGR_ZERO;
      if (ra == CGR_OFF_SRC_A) begin
        next_q.rdata = q.r.src_a;
      end else if (ra == CGR_OFF_SRC_B) begin
        next_q.rdata = q.r.src_b;
      end else if (ra == CGR_OFF_RUN_GATE) begin
        next_q.rdata = q.r.run_gate;
      end else if (ra == CGR_OFF_SLP_GATE) begin
        next_q.rdata = q.r.slp_gate;
      end else if (ra == CGR_OFF_DSL_GATE) begin
        next_q.rdata = q.r.dsl_gate;
      end else if (ra == CGR_OFF_RUN_CFG) begin
        next_q.rdata = q.r.run_cfg;
      end else if (ra == CGR_OFF_CAP_ONE) begin
        next_q.rdata = capabilities_one;
      end else if (ra == CGR_OFF_CAP_TWO) begin
        next_q.rdata = capabilities_two;
      end else if (ra == CGR_OFF_IRQ_STAT) begin
        next_q.rdata = {{(32-CGR_IRQ_BITS){1'b0}}, q.r.irq_stat};
        // Read clears, but an event in the same cycle stays set
        next_q.r.irq_stat = q.r.irq_stat & ~q.r.irq_stat;
        if (fault_now) begin
          next_q.r.irq_stat[CGR_EV_FAULT] = 1'b1;
        end
        if (power_mode != q.last_mode) begin
          next_q.r.irq_stat[CGR_EV_MODE] = 1'b1;
        end
      end else if (ra == CGR_OFF_IRQ_MASK) begin
        next_q.rdata = {{(32-CGR_IRQ_BITS){1'b0}}, q.r.irq_mask};
      end else if (ra == CGR_OFF_STATUS) begin
        next_q.rdata = {{(32-CGR_PORTS){1'b0}}, q.clk_en};
      end
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    // Readies registered so every bus output leaves a flop
    next_q.awready = !next_q.aw_have && !next_q.bvalid;
    next_q.wready  = !next_q.w_have && !next_q.bvalid;
    next_q.arready = !next_q.rvalid;
    next_q.irq = |(next_q.r.irq_stat & next_q.r.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.last_mode <= CGR_MODE_RUN;
      // Ready out of reset, first request taken at once
      q.awready   <= 1'b1;
      q.wready    <= 1'b1;
      q.arready   <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready          = q.awready;
  assign s_axi_wready           = q.wready;
  assign s_axi_bvalid           = q.bvalid;
  assign s_axi_bresp            = q.bresp;
  assign s_axi_arready          = q.arready;
  assign s_axi_rvalid           = q.rvalid;
  assign s_axi_rdata            = q.rdata;
  assign s_axi_rresp            = q.rresp;
  assign port_clk_en            = q.clk_en;
  assign port_access_fault      = q.fault;
  assign hibernation_unit_reset = q.r.src_a[CGR_HIB_BIT];
  assign watchdog_unit_reset    = q.r.src_a[CGR_WDT_BIT];
  assign comparator_zero_reset  = q.r.src_b[CGR_CMP0_BIT];
  assign comparator_one_reset   = q.r.src_b[CGR_CMP1_BIT];
  assign other_unit_reset       = q.r.src_b;
  assign irq                    = q.irq;
endmodule

// *** tb/cgr_top_checker.sv ***
`timescale 1ns/1ps
// Port-level assertions for the clock gating and soft reset block
module cgr_top_checker
  import cgr_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        port_access,
  input wire logic [2:0]  port_access_sel,
  input wire logic [7:0]  port_clk_en,
  input wire logic        port_access_fault,
  input wire logic        comparator_zero_reset,
  input wire logic        comparator_one_reset,
  input wire logic [31:0] other_unit_reset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  gated_fault_a: assert property (
    port_access && !port_clk_en[port_access_sel] && $stable(port_clk_en) |=> port_access_fault)
    else $error("no fault on gated port");
  clocked_ok_a: assert property (
    port_access && port_clk_en[port_access_sel] && $stable(port_clk_en) |=> !port_access_fault)
    else $error("fault on clocked port");
  fault_cause_a: assert property (port_access_fault |-> $past(port_access))
    else $error("fault without access");
  en_reset_a: assert property ($rose(aresetn) |-> port_clk_en == 8'h00)
    else $error("enables not clear after reset");
  cmp_map_a: assert property (comparator_zero_reset == other_unit_reset[CGR_CMP0_BIT]
    && comparator_one_reset == other_unit_reset[CGR_CMP1_BIT]) else $error("comparator reset map");
  b_resv_a: assert property ((other_unit_reset & ~CGR_SRC_B_MASK) == CGR_ZERO)
    else $error("reserved reset bit set");

  cover property (port_access_fault);
  cover property (comparator_one_reset);
  cover property (s_axi_bvalid && s_axi_bresp == CGR_RESP_SLVERR);
endmodule
bind cgr_top cgr_top_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .port_access, .port_access_sel,
  .port_clk_en, .port_access_fault, .comparator_zero_reset, .comparator_one_reset,
  .other_unit_reset);

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// Register-level bench for the clock gating and soft reset block
module testbench;
  import cgr_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, port_access, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, port_access_fault, irq, hibernation_unit_reset;
  logic        watchdog_unit_reset, comparator_zero_reset, comparator_one_reset;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, capabilities_one, capabilities_two, s_axi_rdata, other_unit_reset;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  port_access_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  port_clk_en;
  cgr_mode_t   power_mode;
  int          err_count, n_checks;
  logic [11:0] offs[6] = '{CGR_OFF_SRC_A, CGR_OFF_SRC_B, CGR_OFF_RUN_GATE, CGR_OFF_SLP_GATE,
                           CGR_OFF_DSL_GATE, CGR_OFF_RUN_CFG};
  cgr_mode_t   md[3] = '{CGR_MODE_RUN, CGR_MODE_SLEEP, CGR_MODE_DEEP};
  logic [7:0]  ex[3] = '{8'h0F, 8'hF0, 8'h3C};

  cgr_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .capabilities_one, .capabilities_two, .power_mode, .port_access,
    .port_access_sel, .port_clk_en, .port_access_fault, .hibernation_unit_reset,
    .watchdog_unit_reset, .comparator_zero_reset, .comparator_one_reset, .other_unit_reset, .irq);

  always #25 aclk = ~aclk;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge aclk);
      // Each channel released on its own ready
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1;
        s_axi_bready <= 1'b0;
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
      end
    end
    if (!done) begin
      err_count++;
      conclude();
    end
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1;
        s_axi_rready <= 1'b0;
        chk($sformatf("rdata %h", a), e, s_axi_rdata);
      end
    end
    if (!done) begin
      err_count++;
      conclude();
    end
  endtask

  task acc(input logic [2:0] p, input logic f);
    @(posedge aclk);
    port_access <= 1'b1;
    port_access_sel <= p;
    @(posedge aclk);
    port_access <= 1'b0;
    #1 chk("port_access_fault", {31'h0, f}, {31'h0, port_access_fault});
  endtask

  task irq_is(input logic v);
    repeat (3) @(posedge aclk);
    #1 chk("irq", {31'h0, v}, {31'h0, irq});
  endtask

  initial begin
    aclk = 0; aresetn = 0; s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0;
    s_axi_arvalid = 0; s_axi_rready = 0; port_access = 0; port_access_sel = 3'h0;
    s_axi_awaddr = 12'h000; s_axi_araddr = 12'h000; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
    capabilities_one = 32'hFFFF_FFFF; capabilities_two = 32'hFFFF_FFFF; power_mode = CGR_MODE_RUN;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[k]) rd(offs[k], CGR_ZERO);
    $display("test reset values done");
    wr(CGR_OFF_SLP_GATE, 32'hFFFF_FFFF, CGR_RESP_OKAY);
    rd(CGR_OFF_SLP_GATE, CGR_PORT_MASK);
    wr(CGR_OFF_DSL_GATE, 32'hFFFF_FF3C, CGR_RESP_OKAY);
    rd(CGR_OFF_DSL_GATE, 32'h0000_003C);
    wr(CGR_OFF_SLP_GATE, 32'h0000_00F0, CGR_RESP_OKAY);
    wr(CGR_OFF_RUN_GATE, 32'h0000_000F, CGR_RESP_OKAY);
    for (int a = 0; a < 2; a++) begin
      wr(CGR_OFF_RUN_CFG, a ? 32'h0800_0000 : CGR_ZERO, CGR_RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
        @(posedge aclk);
        power_mode <= md[k];
        repeat (3) @(posedge aclk);
        #1 chk("port_clk_en", {24'h0, a ? ex[k] : ex[0]}, {24'h0, port_clk_en});
        rd(CGR_OFF_STATUS, {24'h0, a ? ex[k] : ex[0]});
      end
    end
    $display("test mode selection done");
    wr(CGR_OFF_IRQ_MASK, 32'h0000_0001, CGR_RESP_OKAY);
    acc(3'h0, 1'b1);
    irq_is(1'b1);
    rd(CGR_OFF_IRQ_STAT, 32'h0000_0003);
    irq_is(1'b0);
    acc(3'h2, 1'b0);
    wr(CGR_OFF_IRQ_MASK, CGR_ZERO, CGR_RESP_OKAY);
    acc(3'h7, 1'b1);
    irq_is(1'b0);
    rd(CGR_OFF_IRQ_STAT, 32'h0000_0001);
    $display("test bus fault done");
    wr(CGR_OFF_SRC_A, 32'hFFFF_FFFF, CGR_RESP_OKAY);
    rd(CGR_OFF_SRC_A, CGR_SRC_A_MASK);
    chk("hib_wdt", 32'h3, {30'h0, hibernation_unit_reset, watchdog_unit_reset});
    @(posedge aclk);
    capabilities_one <= 32'hFFFF_FFF7;
    wr(CGR_OFF_SRC_A, CGR_ZERO, CGR_RESP_OKAY);
    rd(CGR_OFF_SRC_A, 32'h0000_0008);
    chk("hib_wdt", 32'h1, {30'h0, hibernation_unit_reset, watchdog_unit_reset});
    wr(CGR_OFF_SRC_B, 32'hFFFF_FFFF, CGR_RESP_OKAY);
    rd(CGR_OFF_SRC_B, CGR_SRC_B_MASK);
    chk("cmp", 32'h3, {30'h0, comparator_one_reset, comparator_zero_reset});
    @(posedge aclk);
    capabilities_two <= 32'hFEFF_FFFF;
    wr(CGR_OFF_SRC_B, CGR_ZERO, CGR_RESP_OKAY);
    rd(CGR_OFF_SRC_B, 32'h0100_0000);
    chk("other_unit_reset", 32'h0100_0000, other_unit_reset);
    rd(CGR_OFF_CAP_TWO, 32'hFEFF_FFFF);
    wr(12'h300, 32'h0000_0001, CGR_RESP_SLVERR);
    $display("test soft reset done");
    conclude();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    conclude();
  end
endmodule
